//--- logic/lbc_board_ctrl.v
// Notes on behaviour
// - any non-zero byte written to 443h starts the watchdog
// - written byte is timeout in seconds, 1 to 255
// - any read of 444h stops the watchdog; read data meaningless
// - capture post code bytes written to address 80h
// - post code drives eight leds and reads back at 80h
// - version read gives bcd units in 7:4, tenths in 3:0
// - slot register bits 7:5 always read ones
// - slot bits 4:0 mirror five geographic address inputs
// - blue out-of-service led lit during hot insert and removal
// - drone mode disables the backplane bus bridge
// - drive indicator yellow for disk activity, blue for hot removal
// - green indicator shows master or drone mode
`timescale 1ns/1ps
`include "lbc_defs.vh"
module lbc_board_ctrl #(
    parameter TICK_CYCLES = `LBC_TICK_CYCLES,
    parameter [3:0] VER_UNITS = `LBC_VER_UNITS,
    parameter [3:0] VER_TENTHS = `LBC_VER_TENTHS
) (
    // clock and reset
    input wire clk,
    input wire rst,
    // lpc bus
    input wire lpcFrameN,
    input wire [3:0] lpcAdIn,
    output reg [3:0] lpcAdOut_reg,
    output reg lpcAdOe_reg,
    // board pins
    input wire [4:0] slotBits,
    input wire diskActive,
    input wire hotSwapPending,
    input wire droneMode,
    // indicators and controls
    output reg [7:0] postCodeLeds_reg,
    output reg blueLed_reg,
    output reg yellowLed_reg,
    output reg masterDroneLed_reg,
    output reg bridgeEnable_reg,
    output reg boardResetReq_reg,
    output reg powerIndicator_reg
);
    localparam ST_IDLE = 4'h0;
    localparam ST_CYC = 4'h1;
    localparam ST_ADDR = 4'h2;
    localparam ST_WDATA = 4'h3;
    localparam ST_TAR1 = 4'h4;
    localparam ST_TAR2 = 4'h5;
    localparam ST_SYNC = 4'h6;
    localparam ST_RDATA = 4'h7;
    localparam ST_TAR3 = 4'h8;
    localparam ST_TAR4 = 4'h9;

    reg [3:0] state_reg;
    reg [2:0] nib_reg;
    reg isWrite_reg;
    reg [15:0] addr_reg;
    reg [7:0] wdata_reg;
    reg [7:0] rdata_reg;
    reg wdtLoad_reg;
    reg wdtStop_reg;
    reg [4:0] slotS1_reg;
    reg [4:0] slotS2_reg;
    reg [2:0] pinS1_reg;
    reg [2:0] pinS2_reg;
    reg [7:0] readMux;
    wire wdtExpired;
    wire wdtRunning;

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            slotS1_reg <= 5'h00;
            slotS2_reg <= 5'h00;
            pinS1_reg <= 3'h0;
            pinS2_reg <= 3'h0;
        end else begin
            slotS1_reg <= slotBits;
            slotS2_reg <= slotS1_reg;
            pinS1_reg <= {droneMode, hotSwapPending, diskActive};
            pinS2_reg <= pinS1_reg;
        end
    end

    // ----------------------------------------
    // read data select
    // ----------------------------------------
    always @* begin
        case (addr_reg)
            `LBC_ADDR_POST: readMux = postCodeLeds_reg;
            `LBC_ADDR_VERSION: readMux = {VER_UNITS, VER_TENTHS};
            `LBC_ADDR_SLOT: readMux = {`LBC_SLOT_FILL, slotS2_reg};
            default: readMux = 8'h00;
        endcase
    end

    // ----------------------------------------
    // lpc io target
    // ----------------------------------------
    // frame and ad are sampled on clk; lpc runs on this same clock
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg <= ST_IDLE;
            nib_reg <= 3'h0;
            isWrite_reg <= 1'b0;
            addr_reg <= 16'h0000;
            wdata_reg <= 8'h00;
            rdata_reg <= 8'h00;
            lpcAdOut_reg <= `LBC_TAR_IDLE;
            lpcAdOe_reg <= 1'b0;
            postCodeLeds_reg <= `LBC_POST_RST;
            wdtLoad_reg <= 1'b0;
            wdtStop_reg <= 1'b0;
        end else begin
            wdtLoad_reg <= 1'b0;
            wdtStop_reg <= 1'b0;
            if (!lpcFrameN) begin
                // frame low always aborts a cycle; restarts only on the start code
                lpcAdOe_reg <= 1'b0;
                state_reg <= (lpcAdIn == `LBC_START_CODE) ? ST_CYC : ST_IDLE;
            end else begin
                case (state_reg)
                    ST_IDLE: begin
                        state_reg <= ST_IDLE;
                    end
                    ST_CYC: begin
                        nib_reg <= 3'h0;
                        isWrite_reg <= (lpcAdIn == `LBC_CT_IO_WR);
                        if (lpcAdIn == `LBC_CT_IO_WR || lpcAdIn == `LBC_CT_IO_RD) begin
                            state_reg <= ST_ADDR;
                        end else begin
                            state_reg <= ST_IDLE;
                        end
                    end
                    ST_ADDR: begin
                        addr_reg <= {addr_reg[11:0], lpcAdIn};
                        nib_reg <= nib_reg + 3'h1;
                        if (nib_reg == 3'h3) begin
                            state_reg <= isWrite_reg ? ST_WDATA : ST_TAR1;
                            nib_reg <= 3'h0;
                        end
                    end
                    ST_WDATA: begin
                        // data arrives low nibble first
                        wdata_reg <= {lpcAdIn, wdata_reg[7:4]};
                        nib_reg <= nib_reg + 3'h1;
                        if (nib_reg == 3'h1) begin
                            state_reg <= ST_TAR1;
                        end
                    end
                    ST_TAR1: begin
                        state_reg <= ST_TAR2;
                    end
                    ST_TAR2: begin
                        // unmapped addresses get no sync; host sees abort
                        if (isWrite_reg ? (addr_reg == `LBC_ADDR_POST ||
                                addr_reg == `LBC_ADDR_WDT_EN) :
                                (addr_reg == `LBC_ADDR_POST ||
                                addr_reg == `LBC_ADDR_WDT_DIS ||
                                addr_reg == `LBC_ADDR_VERSION ||
                                addr_reg == `LBC_ADDR_SLOT)) begin
                            state_reg <= ST_SYNC;
                            lpcAdOut_reg <= `LBC_SYNC_READY;
                            lpcAdOe_reg <= 1'b1;
                            rdata_reg <= readMux;
                        end else begin
                            state_reg <= ST_IDLE;
                        end
                    end
                    ST_SYNC: begin
                        nib_reg <= 3'h0;
                        if (isWrite_reg) begin
                            lpcAdOut_reg <= `LBC_TAR_IDLE;
                            state_reg <= ST_TAR3;
                            if (addr_reg == `LBC_ADDR_POST) begin
                                postCodeLeds_reg <= wdata_reg;
                            end else begin
                                wdtLoad_reg <= 1'b1;
                            end
                        end else begin
                            lpcAdOut_reg <= rdata_reg[3:0];
                            state_reg <= ST_RDATA;
                            if (addr_reg == `LBC_ADDR_WDT_DIS) begin
                                wdtStop_reg <= 1'b1;
                            end
                        end
                    end
                    ST_RDATA: begin
                        lpcAdOut_reg <= rdata_reg[7:4];
                        nib_reg <= nib_reg + 3'h1;
                        if (nib_reg == 3'h1) begin
                            lpcAdOut_reg <= `LBC_TAR_IDLE;
                            state_reg <= ST_TAR3;
                        end
                    end
                    ST_TAR3: begin
                        state_reg <= ST_TAR4;
                    end
                    ST_TAR4: begin
                        lpcAdOe_reg <= 1'b0;
                        state_reg <= ST_IDLE;
                    end
                    default: begin
                        state_reg <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // ----------------------------------------
    // watchdog
    // ----------------------------------------
    lbc_watchdog #(
        .TICK_CYCLES(TICK_CYCLES)
    ) wdt (
        .clk(clk),
        .rst(rst),
        .loadStb(wdtLoad_reg),
        .loadVal(wdata_reg),
        .stopStb(wdtStop_reg),
        .running_reg(wdtRunning),
        .expired_reg(wdtExpired)
    );

    // ----------------------------------------
    // board indicators
    // ----------------------------------------
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            blueLed_reg <= 1'b0;
            yellowLed_reg <= 1'b0;
            masterDroneLed_reg <= 1'b0;
            bridgeEnable_reg <= 1'b0;
            boardResetReq_reg <= 1'b0;
            powerIndicator_reg <= 1'b0;
        end else begin
            blueLed_reg <= pinS2_reg[1];
            // blue has priority so a pending removal is never hidden
            yellowLed_reg <= pinS2_reg[0] & ~pinS2_reg[1];
            masterDroneLed_reg <= ~pinS2_reg[2];
            bridgeEnable_reg <= ~pinS2_reg[2];
            boardResetReq_reg <= wdtExpired;
            powerIndicator_reg <= 1'b1;
        end
    end
endmodule // lbc_board_ctrl

//--- logic/lbc_defs.vh
`ifndef LBC_DEFS_VH
`define LBC_DEFS_VH
// ----------------------------------------
// io addresses
// ----------------------------------------
`define LBC_ADDR_POST 16'h0080
`define LBC_ADDR_WDT_EN 16'h0443
`define LBC_ADDR_WDT_DIS 16'h0444
`define LBC_ADDR_VERSION 16'h0445
`define LBC_ADDR_SLOT 16'h0447
// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define LBC_SLOT_FILL 3'h7
`define LBC_POST_RST 8'h00
`define LBC_VER_UNITS 4'h1
`define LBC_VER_TENTHS 4'h0
// ----------------------------------------
// lpc cycle codes
// ----------------------------------------
`define LBC_START_CODE 4'h0
`define LBC_CT_IO_RD 4'h0
`define LBC_CT_IO_WR 4'h2
`define LBC_SYNC_READY 4'h0
`define LBC_TAR_IDLE 4'hF
// ----------------------------------------
// timing
// ----------------------------------------
`define LBC_CLK_HZ 200000000
`define LBC_TICK_SEC 1
`define LBC_TICK_CYCLES (`LBC_CLK_HZ * `LBC_TICK_SEC)
`endif

//--- logic/lbc_watchdog.v
`timescale 1ns/1ps
`include "lbc_defs.vh"
module lbc_watchdog #(
    parameter TICK_CYCLES = `LBC_TICK_CYCLES
) (
    // clock and reset
    input wire clk,
    input wire rst,
    // control
    input wire loadStb,
    input wire [7:0] loadVal,
    input wire stopStb,
    // status
    output reg running_reg,
    output reg expired_reg
);
    reg [31:0] tickCnt_reg;
    reg [7:0] secLeft_reg;
    wire tick;
    wire expiring;

    // ----------------------------------------
    // one-second time base
    // ----------------------------------------
    // free running, so the first second after a load may be short
    assign tick = (tickCnt_reg == TICK_CYCLES - 1);
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            tickCnt_reg <= 32'h00000000;
        end else if (tick) begin
            tickCnt_reg <= 32'h00000000;
        end else begin
            tickCnt_reg <= tickCnt_reg + 32'h00000001;
        end
    end

    // ----------------------------------------
    // countdown
    // ----------------------------------------
    assign expiring = running_reg && tick && (secLeft_reg == 8'h01);
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            running_reg <= 1'b0;
            secLeft_reg <= 8'h00;
            expired_reg <= 1'b0;
        end else if (stopStb) begin
            running_reg <= 1'b0;
            // an expiry in the same cycle beats the clear
            expired_reg <= expiring;
        end else if (loadStb && loadVal != 8'h00) begin
            running_reg <= 1'b1;
            secLeft_reg <= loadVal;
            expired_reg <= expiring;
        end else if (running_reg && tick) begin
            if (secLeft_reg == 8'h01) begin
                running_reg <= 1'b0;
                expired_reg <= 1'b1;
            end
            secLeft_reg <= secLeft_reg - 8'h01;
        end
    end
endmodule // lbc_watchdog

//--- tb/lbc_board_ctrl_asserts.sv
`timescale 1ns/1ps
module lbc_board_ctrl_asserts (
    // clock and reset
    input logic clk,
    input logic rst,
    // bus and pins
    input logic [3:0] lpcAdOut_reg,
    input logic lpcAdOe_reg,
    input logic diskActive,
    input logic hotSwapPending,
    input logic droneMode,
    // outputs
    input logic [7:0] postCodeLeds_reg,
    input logic blueLed_reg,
    input logic yellowLed_reg,
    input logic masterDroneLed_reg,
    input logic bridgeEnable_reg,
    input logic boardResetReq_reg,
    input logic powerIndicator_reg
);
    // pins pass synchronisers, so wait those out after reset
    logic [2:0] runCnt_reg;
    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            runCnt_reg <= 3'h0;
        else if (runCnt_reg != 3'h7)
            runCnt_reg <= runCnt_reg + 3'h1;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence pinsHeld;
        (runCnt_reg == 3'h7 &&
            $stable({diskActive, hotSwapPending, droneMode}))[*4];
    endsequence
    sequence answerShape;
        lpcAdOe_reg[*3] ##[1:3] !lpcAdOe_reg;
    endsequence
    blue_led_a:
        assert property (pinsHeld |-> blueLed_reg == hotSwapPending)
        else $error("blue led wrong");
    bridge_off_a:
        assert property (pinsHeld |-> bridgeEnable_reg == !droneMode)
        else $error("bridge enable wrong");
    disk_led_a:
        assert property (pinsHeld |->
            yellowLed_reg == (diskActive && !hotSwapPending))
        else $error("disk led wrong");
    mode_led_a:
        assert property (pinsHeld |-> masterDroneLed_reg == !droneMode)
        else $error("mode led wrong");
    post_on_write_a:
        assert property (!$stable(postCodeLeds_reg) |->
            lpcAdOe_reg || $past(lpcAdOe_reg))
        else $error("post leds moved outside a cycle");
    req_holds_a:
        assert property ((boardResetReq_reg && !lpcAdOe_reg)[*3] |=>
            boardResetReq_reg)
        else $error("reset request dropped");
    sync_first_a:
        assert property ($rose(lpcAdOe_reg) |-> lpcAdOut_reg == 4'h0)
        else $error("answer not led by ready sync");
    oe_span_a:
        assert property ($rose(lpcAdOe_reg) |-> answerShape)
        else $error("bus drive span wrong");
    power_on_a:
        assert property (runCnt_reg == 3'h7 |-> powerIndicator_reg)
        else $error("power indicator off");
endmodule // lbc_board_ctrl_asserts
bind lbc_board_ctrl lbc_board_ctrl_asserts u_chk (
    .clk(clk), .rst(rst), .lpcAdOut_reg(lpcAdOut_reg),
    .lpcAdOe_reg(lpcAdOe_reg), .diskActive(diskActive),
    .hotSwapPending(hotSwapPending), .droneMode(droneMode),
    .postCodeLeds_reg(postCodeLeds_reg), .blueLed_reg(blueLed_reg),
    .yellowLed_reg(yellowLed_reg), .masterDroneLed_reg(masterDroneLed_reg),
    .bridgeEnable_reg(bridgeEnable_reg),
    .boardResetReq_reg(boardResetReq_reg),
    .powerIndicator_reg(powerIndicator_reg)
);

//--- tb/lbc_board_ctrl_test.sv
`timescale 1ns/1ps
module lbc_board_ctrl_test;
    localparam int TICK = 10;
    logic clk, rst, lpcFrameN, lpcAdOe_reg, diskActive, hotSwapPending;
    logic droneMode, blueLed_reg, yellowLed_reg, masterDroneLed_reg, ok;
    logic bridgeEnable_reg, boardResetReq_reg, powerIndicator_reg;
    logic [3:0] adBus, lpcAdOut_reg;
    logic [4:0] slotBits;
    logic [7:0] postCodeLeds_reg, q, r;
    logic [7:0] postQ [$];
    logic [31:0] rngState = 32'h00000460;
    int failures = 0, checkCount = 0, i;
    lbc_board_ctrl #(.TICK_CYCLES(TICK)) u_dut (
        .clk(clk), .rst(rst), .lpcFrameN(lpcFrameN), .lpcAdIn(adBus),
        .lpcAdOut_reg(lpcAdOut_reg), .lpcAdOe_reg(lpcAdOe_reg),
        .slotBits(slotBits), .diskActive(diskActive),
        .hotSwapPending(hotSwapPending), .droneMode(droneMode),
        .postCodeLeds_reg(postCodeLeds_reg), .blueLed_reg(blueLed_reg),
        .yellowLed_reg(yellowLed_reg), .masterDroneLed_reg(masterDroneLed_reg),
        .bridgeEnable_reg(bridgeEnable_reg),
        .boardResetReq_reg(boardResetReq_reg),
        .powerIndicator_reg(powerIndicator_reg));
    lbc_lpc_host u_host (.clk(clk), .lpcFrameN(lpcFrameN), .adBus(adBus),
        .lpcAdOut_reg(lpcAdOut_reg), .lpcAdOe_reg(lpcAdOe_reg));
    function automatic logic [7:0] rnd();
        rngState ^= rngState << 13;
        rngState ^= rngState >> 17;
        rngState ^= rngState << 5;
        return rngState[7:0];
    endfunction
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checkCount++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic ioWrite(input logic [15:0] a, input logic [7:0] d,
            input logic eo);
        u_host.xfer(1'b1, a, d, q, ok);
        check({7'h0, ok}, {7'h0, eo});
    endtask
    task automatic ioRead(input logic [15:0] a, input logic eo);
        u_host.xfer(1'b0, a, 8'h00, q, ok);
        check({7'h0, ok}, {7'h0, eo});
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic finish_test();
        $display("checks %0d failures %0d", checkCount, failures);
        if (failures == 0 && checkCount > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // whole run is near 3300 cycles; allow six times that
    initial begin
        #100000;
        failures++;
        finish_test();
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        rst = 1'b1;
        {diskActive, hotSwapPending, droneMode} = 3'h0;
        slotBits = 5'h00;
        cyc(16);
        rst <= 1'b0;
        cyc(8);
        check(postCodeLeds_reg, 8'h00);
        check({7'h0, powerIndicator_reg}, 8'h01);
        for (i = 0; i < 4; i++) begin
            postQ.push_back(rnd());
            ioWrite(16'h0080, postQ[$], 1'b1);
            check(postCodeLeds_reg, postQ[$]);
            ioRead(16'h0080, 1'b1);
            check(q, postQ[$]);
        end
        ioRead(16'h0445, 1'b1);
        check(q, 8'h10);
        for (i = 0; i < 3; i++) begin
            r = rnd();
            slotBits <= r[4:0];
            cyc(4);
            ioRead(16'h0447, 1'b1);
            check(q, {3'h7, r[4:0]});
        end
        for (i = 0; i < 8; i++) begin
            {diskActive, hotSwapPending, droneMode} <= i[2:0];
            cyc(5);
            check({blueLed_reg, yellowLed_reg, masterDroneLed_reg,
                bridgeEnable_reg}, {4'h0, i[1], i[2] & !i[1], !i[0], !i[0]
                });
        end
        // unmapped, read-only and write-only places get no answer
        ioRead(16'h0446, 1'b0);
        ioWrite(16'h0445, 8'h55, 1'b0);
        ioRead(16'h0443, 1'b0);
        ioWrite(16'h0443, 8'h03, 1'b1);
        cyc(15);
        check({7'h0, boardResetReq_reg}, 8'h00);
        cyc(18);
        check({7'h0, boardResetReq_reg}, 8'h01);
        ioRead(16'h0444, 1'b1);
        check({7'h0, boardResetReq_reg}, 8'h00);
        // a zero byte must neither refresh nor stop a running count
        ioWrite(16'h0443, 8'h03, 1'b1);
        ioWrite(16'h0443, 8'h00, 1'b1);
        cyc(18);
        check({7'h0, boardResetReq_reg}, 8'h01);
        ioRead(16'h0444, 1'b1);
        ioWrite(16'h0443, 8'h00, 1'b1);
        cyc(40);
        check({7'h0, boardResetReq_reg}, 8'h00);
        ioWrite(16'h0443, 8'hFF, 1'b1);
        cyc(254 * TICK - 15);
        check({7'h0, boardResetReq_reg}, 8'h00);
        cyc(TICK + 30);
        check({7'h0, boardResetReq_reg}, 8'h01);
        ioWrite(16'h0443, 8'h01, 1'b1);
        cyc(14);
        check({7'h0, boardResetReq_reg}, 8'h01);
        repeat (5) begin
            cyc(2);
            ioWrite(16'h0443, 8'h04, 1'b1);
        end
        check({7'h0, boardResetReq_reg}, 8'h00);
        ioRead(16'h0444, 1'b1);
        cyc(60);
        check({7'h0, boardResetReq_reg}, 8'h00);
        // mid-run reset clears the captured code
        ioWrite(16'h0080, 8'hA5, 1'b1);
        rst <= 1'b1;
        cyc(3);
        check(postCodeLeds_reg, 8'h00);
        check({7'h0, boardResetReq_reg}, 8'h00);
        rst <= 1'b0;
        cyc(2);
        check({7'h0, powerIndicator_reg}, 8'h01);
        ioRead(16'h0080, 1'b1);
        check(q, 8'h00);
        finish_test();
    end
endmodule // lbc_board_ctrl_test

//--- tb/lbc_lpc_host.sv
`timescale 1ns/1ps
module lbc_lpc_host (
    // clock
    input logic clk,
    // lpc bus
    output logic lpcFrameN,
    output logic [3:0] adBus,
    input logic [3:0] lpcAdOut_reg,
    input logic lpcAdOe_reg
);
    logic [3:0] hostAd;
    logic hostOe;
    // bus is pulled up: a released line reads F
    assign adBus = lpcAdOe_reg ? lpcAdOut_reg : (hostOe ? hostAd : 4'hF);
    initial begin
        lpcFrameN = 1'b1;
        hostAd = 4'hF;
        hostOe = 1'b0;
    end
    // ok stays low when the device never syncs
    task automatic xfer(input logic wr, input logic [15:0] a,
            input logic [7:0] d, output logic [7:0] q, output logic ok);
        logic [3:0] n [0:7];
        int i;
        n = '{4'h0, wr ? 4'h2 : 4'h0, a[15:12], a[11:8], a[7:4], a[3:0],
            d[3:0], d[7:4]};
        q = 8'hFF;
        ok = 1'b0;
        for (i = 0; i < (wr ? 8 : 6); i++) begin
            @(posedge clk);
            lpcFrameN <= (i != 0);
            hostAd <= n[i];
            hostOe <= 1'b1;
        end
        @(posedge clk);
        hostAd <= 4'hF;
        @(posedge clk);
        hostOe <= 1'b0;
        for (i = 0; i < 8 && !ok; i++) begin
            @(posedge clk);
            ok = (lpcAdOe_reg === 1'b1) && (lpcAdOut_reg === 4'h0);
        end
        if (ok && !wr) begin
            @(posedge clk);
            q[3:0] = lpcAdOut_reg;
            @(posedge clk);
            q[7:4] = lpcAdOut_reg;
        end
        for (i = 0; i < 6 && lpcAdOe_reg !== 1'b0; i++)
            @(posedge clk);
    endtask
endmodule // lbc_lpc_host
